//--- src/usi_defs.vh
`ifndef USI_DEFS_VH
`define USI_DEFS_VH
// Register byte addresses
`define USI_ADDR_MODE     8'h00
`define USI_ADDR_STAT     8'h04
`define USI_ADDR_DATA     8'h08
`define USI_ADDR_SADR     8'h0C
`define USI_ADDR_TOUT     8'h10
`define USI_ADDR_W        8
// Reset values
`define USI_MODE_RST      8'hE0
`define USI_SADR_RST      8'h00
`define USI_STAT_RST      8'h81
`define USI_ZERO8         8'h00
// Mode register fields
`define USI_OPM_HI        7
`define USI_OPM_LO        5
`define USI_UART_BIT      4
`define USI_DEB_HI        3
`define USI_DEB_LO        2
`define USI_EN_BIT        1
`define USI_ICF_BIT       0
// Operating mode codes
`define USI_OPM_SPI_D4    3'b000
`define USI_OPM_SPI_D16   3'b001
`define USI_OPM_SPI_D64   3'b010
`define USI_OPM_SPI_SUB   3'b011
`define USI_OPM_SPI_TMR   3'b100
`define USI_OPM_SPI_SLV   3'b101
`define USI_OPM_I2C       3'b110
`define USI_OPM_UNUSED    3'b111
// Debounce codes and lengths
`define USI_DEB_NONE      2'b00
`define USI_DEB_TWO       2'b01
`define USI_DEB_LEN2      3'd2
`define USI_DEB_LEN4      3'd4
`define USI_DEB_LEN0      3'd0
// Status register fields
`define USI_ST_CPL        7
`define USI_ST_HIT        6
`define USI_ST_BSY        5
`define USI_ST_TXD        4
`define USI_ST_AKC        3
`define USI_ST_RW         2
`define USI_ST_WU         1
`define USI_ST_RAK        0
// Bit counts
`define USI_BIT_LAST      4'd8
`define USI_BIT_ZERO      4'd0
`define USI_BIT_ONE       4'd1
// AHB encodings
`define USI_HTRANS_NONSEQ 2'b10
`endif

//--- src/usi_i2c_slave.v
// Functional notes
// - SDA and SCL are driven open-drain: only low or released.
// - Slave only; supports slave transmit and slave receive.
// - No chip select; selected when bus address equals stored address.
// - Address register bits 7..1 hold the 7-bit address; reset zero.
// - Address register bit 0 is plain read/write storage, unused.
// - One data register loaded before transmit, read after receive.
// - Optional SCL debounce of 2 or 4 system clocks.
// - Debounce code 00 none, 01 two clocks, 10 and 11 four clocks.
// - Debounce applies only when UART bit 0 and mode is 110.
// - Mode 000-100 SPI master, 101 SPI slave, 110 I2C, 111 unused.
// - SPI master clock code decodes sys/4, /16, /64, sub, timer/2.
// - Mode field counts only while UART bit is clear.
// - I2C register forms exist only while I2C mode selected.
// - Address register doubles as SPI control two in SPI mode.
// - Pull-up control stays effective while I2C is active.
// - Mode resets to 111; UART, debounce, enable, flag bits to 0.
// - Enable bit switches unit; cleared releases lines, unit idles.
// - Enabling in I2C resets status flags, keeps direction and ack.
`include "usi_defs.vh"
`default_nettype none

module usi_i2c_slave
(
    // System
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        clk_en,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // I2C pins, open drain
    input  wire        scl_in,
    output reg         scl_out,
    output reg         scl_oe,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // Pull-up control and mode decode
    input  wire        pullup_req,
    output reg         pullup_en,
    output reg         spi_mode,
    output reg  [2:0]  spi_clk_sel
);

    // ========================================
    // Registers and state
    // ========================================
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_ADDR = 5'b00010;
    localparam [4:0] ST_RX   = 5'b00100;
    localparam [4:0] ST_TX   = 5'b01000;
    localparam [4:0] ST_ACK  = 5'b10000;

    reg [7:0] mode_r;
    reg [7:0] sadr_r;
    reg [7:0] data_r;
    reg [7:0] tout_r;
    reg       cpl_r, hit_r, bsy_r, txd_r, akc_r, rw_r, wu_r, rak_r;
    reg [4:0] state_r;
    reg [7:0] shift_r;
    reg [3:0] bitc_r;
    reg       ackph_r;
    reg [2:0] deb_cnt_r;
    reg       scl_f_r, scl_d_r, sda_d_r;
    reg       en_d_r;
    reg       ap_wr_r, ap_rd_r;
    reg [7:0] ap_addr_r;

    wire [2:0] opm    = mode_r[`USI_OPM_HI:`USI_OPM_LO];
    wire       uart   = mode_r[`USI_UART_BIT];
    wire       en     = mode_r[`USI_EN_BIT];
    wire       i2c_md = ~uart && (opm == `USI_OPM_I2C);
    wire       act    = i2c_md && en;
    wire [1:0] deb    = mode_r[`USI_DEB_HI:`USI_DEB_LO];

    // Debounce length, forced to zero outside I2C mode
    wire [2:0] deb_len = !i2c_md ? `USI_DEB_LEN0 :
                         (deb == `USI_DEB_NONE) ? `USI_DEB_LEN0 :
                         (deb == `USI_DEB_TWO) ? `USI_DEB_LEN2 :
                         `USI_DEB_LEN4;

    wire [7:0] stat_v = {cpl_r, hit_r, bsy_r, txd_r,
                         akc_r, rw_r, wu_r, rak_r};

    // ========================================
    // SCL debounce
    // ========================================
    // Counter restarts whenever input and filtered level agree, so a glitch
    // shorter than the length never reaches the protocol logic
    wire scl_fnxt = (deb_len == `USI_DEB_LEN0) ? scl_in :
                    (scl_in != scl_f_r && deb_cnt_r + 3'd1 >= deb_len)
                    ? scl_in : scl_f_r;
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            deb_cnt_r <= `USI_DEB_LEN0;
            scl_f_r   <= 1'b1;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
        end
        else if (clk_en)
        begin
            if (scl_in == scl_f_r || scl_fnxt != scl_f_r)
                deb_cnt_r <= `USI_DEB_LEN0;
            else
                deb_cnt_r <= deb_cnt_r + 3'd1;
            scl_f_r <= scl_fnxt;
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_in;
        end
    end

    wire scl_rise = scl_f_r & ~scl_d_r;
    wire scl_fall = ~scl_f_r & scl_d_r;
    wire start_c  = scl_f_r & scl_d_r & sda_d_r & ~sda_in;
    wire stop_c   = scl_f_r & scl_d_r & ~sda_d_r & sda_in;

    // ========================================
    // AHB-Lite slave: one wait-free data phase
    // ========================================
    wire ap_take = hsel && hready && (htrans == `USI_HTRANS_NONSEQ);
    wire wr_mode = ap_wr_r && ap_addr_r == `USI_ADDR_MODE;
    wire wr_stat = ap_wr_r && ap_addr_r == `USI_ADDR_STAT && i2c_md;
    wire wr_data = ap_wr_r && ap_addr_r == `USI_ADDR_DATA;
    wire wr_sadr = ap_wr_r && ap_addr_r == `USI_ADDR_SADR;
    wire wr_tout = ap_wr_r && ap_addr_r == `USI_ADDR_TOUT && i2c_md;
    wire rd_data = ap_rd_r && ap_addr_r == `USI_ADDR_DATA;

    // Read mux; status and time-out read zero outside I2C mode
    reg [7:0] rd_v;
    always @*
    begin
        case (haddr[`USI_ADDR_W-1:0])
            `USI_ADDR_MODE: rd_v = mode_r;
            `USI_ADDR_STAT: rd_v = i2c_md ? stat_v : `USI_ZERO8;
            `USI_ADDR_DATA: rd_v = data_r;
            `USI_ADDR_SADR: rd_v = sadr_r;
            `USI_ADDR_TOUT: rd_v = i2c_md ? tout_r : `USI_ZERO8;
            default:        rd_v = `USI_ZERO8;
        endcase
    end

    // Read word latched in the address phase, so no wait state
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= `USI_ZERO8;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (clk_en)
        begin
            ap_wr_r   <= ap_take && hwrite;
            ap_rd_r   <= ap_take && !hwrite;
            ap_addr_r <= haddr[`USI_ADDR_W-1:0];
            if (ap_take && !hwrite)
                hrdata <= {24'h00_0000, rd_v};
        end
    end

    // ========================================
    // Configuration registers
    // ========================================
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_r <= `USI_MODE_RST;
            sadr_r <= `USI_SADR_RST;
            tout_r <= `USI_ZERO8;
            en_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_mode)
                mode_r <= hwdata[7:0];
            if (wr_sadr)
                sadr_r <= hwdata[7:0];
            if (wr_tout)
                tout_r <= hwdata[7:0];
            en_d_r <= en;
        end
    end

    // ========================================
    // I2C slave protocol
    // ========================================
    wire addr_hit = (shift_r[7:1] == sadr_r[7:1]);
    wire en_rise  = en & ~en_d_r & i2c_md;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            shift_r <= `USI_ZERO8;
            data_r  <= `USI_ZERO8;
            bitc_r  <= `USI_BIT_ZERO;
            ackph_r <= 1'b0;
            cpl_r   <= 1'b1;
            hit_r   <= 1'b0;
            bsy_r   <= 1'b0;
            txd_r   <= 1'b0;
            akc_r   <= 1'b0;
            rw_r    <= 1'b0;
            wu_r    <= 1'b0;
            rak_r   <= 1'b1;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_stat)
            begin
                txd_r  <= hwdata[`USI_ST_TXD];
                akc_r  <= hwdata[`USI_ST_AKC];
                wu_r   <= hwdata[`USI_ST_WU];
            end
            if (wr_data || rd_data)
            begin
                hit_r  <= 1'b0;
                cpl_r  <= 1'b0;
            end
            if (wr_data)
                data_r <= hwdata[7:0];
            if (!act)
            begin
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
            end
            else if (en_rise)
            begin
                // Flags to defaults; direction and ack kept
                cpl_r   <= 1'b1;
                hit_r   <= 1'b0;
                bsy_r   <= 1'b0;
                rw_r    <= 1'b0;
                rak_r   <= 1'b1;
                state_r <= ST_IDLE;
            end
            else if (stop_c)
            begin
                bsy_r   <= 1'b0;
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
            end
            else if (start_c)
            begin
                bsy_r   <= 1'b1;
                hit_r   <= 1'b0;
                bitc_r  <= `USI_BIT_ZERO;
                state_r <= ST_ADDR;
                sda_oe  <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                        sda_oe <= 1'b0;
                    ST_ADDR, ST_RX:
                    begin
                        if (scl_rise && bitc_r != `USI_BIT_LAST)
                        begin
                            shift_r <= {shift_r[6:0], sda_d_r};
                            bitc_r  <= bitc_r + `USI_BIT_ONE;
                        end
                        else if (scl_fall && bitc_r == `USI_BIT_LAST)
                        begin
                            bitc_r <= `USI_BIT_ZERO;
                            if (state_r == ST_ADDR)
                            begin
                                if (addr_hit)
                                begin
                                    hit_r   <= 1'b1;
                                    cpl_r   <= 1'b1;
                                    rw_r    <= shift_r[0];
                                    sda_oe  <= 1'b1;
                                    ackph_r <= shift_r[0];
                                    state_r <= ST_ACK;
                                end
                                else
                                    state_r <= ST_IDLE;
                            end
                            else
                            begin
                                data_r  <= shift_r;
                                cpl_r   <= 1'b1;
                                sda_oe  <= ~akc_r;
                                ackph_r <= 1'b0;
                                state_r <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK:
                        if (scl_fall)
                        begin
                            if (ackph_r)
                            begin
                                // Slave transmit: present MSB
                                shift_r <= {data_r[6:0], 1'b0};
                                sda_oe  <= ~data_r[7];
                                bitc_r  <= `USI_BIT_ONE;
                                state_r <= ST_TX;
                            end
                            else
                            begin
                                sda_oe  <= 1'b0;
                                state_r <= ST_RX;
                            end
                        end
                    ST_TX:
                        if (scl_fall)
                        begin
                            if (bitc_r == `USI_BIT_LAST)
                            begin
                                sda_oe  <= 1'b0;
                                bitc_r  <= `USI_BIT_ZERO;
                            end
                            else if (bitc_r == `USI_BIT_ZERO)
                            begin
                                shift_r <= {data_r[6:0], 1'b0};
                                sda_oe  <= ~data_r[7];
                                bitc_r  <= `USI_BIT_ONE;
                            end
                            else
                            begin
                                sda_oe  <= ~shift_r[7];
                                shift_r <= {shift_r[6:0], 1'b0};
                                bitc_r  <= bitc_r + `USI_BIT_ONE;
                            end
                        end
                        else if (scl_rise && bitc_r == `USI_BIT_ZERO)
                        begin
                            // Master ack bit; NAK ends the transfer
                            rak_r  <= sda_d_r;
                            cpl_r  <= 1'b1;
                            if (sda_d_r)
                                state_r <= ST_IDLE;
                        end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ========================================
    // Pins and mode decode outputs
    // ========================================
    // SCL is never stretched; kept released but open-drain shaped
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_out     <= 1'b0;
            scl_oe      <= 1'b0;
            pullup_en   <= 1'b0;
            spi_mode    <= 1'b0;
            spi_clk_sel <= `USI_OPM_UNUSED;
        end
        else if (clk_en)
        begin
            scl_out     <= 1'b0;
            scl_oe      <= 1'b0;
            pullup_en   <= pullup_req;
            spi_mode    <= ~uart && en &&
                           (opm <= `USI_OPM_SPI_SLV);
            spi_clk_sel <= uart ? `USI_OPM_UNUSED : opm;
        end
    end

endmodule

`default_nettype wire

//--- dv/i2c_slave_assertions.sv
`include "usi_defs.vh"
`default_nettype none
// ========================================================
// Port checker for the serial slave block
module usi_checker
(
    // System
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clk_en,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Serial pins
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    // Pull-up and mode decode
    input wire logic        pullup_req,
    input wire logic        pullup_en,
    input wire logic        spi_mode,
    input wire logic [2:0]  spi_clk_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_r;
    logic       pend_r;
    logic [1:0] age_r;
    // Mirror of mode writes; decode judged only once a write has settled
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_r <= `USI_MODE_RST;
            pend_r <= 1'b0;
            age_r  <= 2'd0;
        end
        else
        begin
            pend_r <= hsel && hready && hwrite && htrans == `USI_HTRANS_NONSEQ
                      && haddr == {24'h00_0000, `USI_ADDR_MODE};
            if (pend_r)
            begin
                mode_r <= hwdata[7:0];
                age_r  <= 2'd0;
            end
            else if (age_r != 2'd3)
                age_r <= age_r + 2'd1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_od_low; !scl_out && !sda_out; endproperty
    a_od_low: assert property (p_od_low)
        else $error("Serial output driven high");
    property p_no_scl; !scl_oe; endproperty
    a_no_scl: assert property (p_no_scl)
        else $error("Slave pulled the clock line");
    property p_oe_edge; $changed(sda_oe) |-> !scl_in; endproperty
    a_oe_edge: assert property (p_oe_edge)
        else $error("Data drive changed while clock high");
    property p_ack_span; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    a_ack_span: assert property (p_ack_span)
        else $error("Data drive pulse too short");
    property p_rst_quiet;
        $fell(rst) |-> hrdata == 32'h0000_0000 && !sda_oe ##1 !sda_oe [*3];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("Lines or read data busy after reset");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("Bus wait or error response");
    property p_pullup;
        $past(clk_en) && !$past(rst) |-> pullup_en == $past(pullup_req);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("Pull-up enable does not follow request");
    property p_spi_mode;
        age_r == 2'd3 |->
            spi_mode == (!mode_r[4] && mode_r[1] && mode_r[7:5] <= 3'b101);
    endproperty
    a_spi_mode: assert property (p_spi_mode)
        else $error("Mode decode wrong");
    property p_clk_sel;
        age_r == 2'd3 |-> spi_clk_sel == (mode_r[4] ? 3'b111 : mode_r[7:5]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("Clock select decode wrong");
    // Main scenarios reached
    c_ack: cover property ($rose(sda_oe));
    c_i2c: cover property (age_r == 2'd3 && mode_r[7:5] == 3'b110);
    c_rst: cover property ($fell(rst));
endmodule
bind usi_i2c_slave usi_checker u_checker
(
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .pullup_req(pullup_req),
    .pullup_en(pullup_en), .spi_mode(spi_mode), .spi_clk_sel(spi_clk_sel)
);
`default_nettype wire

//--- dv/i2c_master_model.sv
`default_nettype none
// ========================================================
// Behavioural bus master on the two serial wires
module usi_bus_master
(
    // System
    input  wire logic clk_sys,
    // Data wire level
    input  wire logic sda,
    // Pull-low drives
    output var  logic scl_low,
    output var  logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quarter bit; long enough for the 4-clock filter at this clock
    localparam int QTR = 12;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Start: data falls while clock high
    task automatic start();
        tick(QTR);
        sda_low <= 1'b1;
        tick(2 * QTR);
        scl_low <= 1'b1;
    endtask
    // Stop: data rises while clock high; clock then stands high
    task automatic stop();
        tick(QTR);
        sda_low <= 1'b1;
        tick(QTR);
        scl_low <= 1'b0;
        tick(2 * QTR);
        sda_low <= 1'b0;
        tick(2 * QTR);
    endtask
    // One clock pulse; gl above zero pulls the clock low mid-high
    task automatic clock_bit(input logic b, input int gl, output logic s);
        tick(QTR);
        sda_low <= !b;
        tick(QTR);
        scl_low <= 1'b0;
        tick(QTR);
        if (gl > 0)
        begin
            scl_low <= 1'b1;
            tick(gl);
            scl_low <= 1'b0;
        end
        s = sda;
        tick(QTR);
        scl_low <= 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] d, input int gb, input int gl,
                             output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], i == gb ? gl : 0, s);
        clock_bit(1'b1, 0, s);
        ack = !s;
    endtask
    task automatic read_byte(input logic nak, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, 0, s);
            d[i] = s;
        end
        clock_bit(nak, 0, s);
    endtask
endmodule
`default_nettype wire

//--- dv/i2c_slave_config_and_debounce_tb.sv
`include "usi_defs.vh"
`default_nettype none
// ========================================================
// Self-checking bench for the serial slave block
module i2c_slave_config_and_debounce_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, clk_en, hsel, hwrite, pullup_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, spi_clk_sel;
    logic        hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe;
    logic        pullup_en, spi_mode, m_scl, m_sda, ack;
    wire         scl_w, sda_w;
    int          err_total, check_count;
    // Pull-ups: a released wire reads high
    assign scl_w = (scl_oe ? scl_out : 1'b1) & ~m_scl;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_sda;
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    usi_i2c_slave DUT
    (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .pullup_req(pullup_req),
        .pullup_en(pullup_en), .spi_mode(spi_mode), .spi_clk_sel(spi_clk_sel)
    );
    usi_bus_master mst
    (
        .clk_sys(clk_sys), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda)
    );
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for hready sampled high at an edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
    endtask
    // Single word transfer; read byte taken at the data phase edge
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= `USI_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        wait_rdy();
        rd = hrdata[7:0];
    endtask
    function automatic logic [7:0] mb(input logic [2:0] op, input logic u,
                                      input logic [1:0] deb, input logic en);
        return {op, u, deb, en, 1'b0};
    endfunction
    task automatic t_regs();
        logic [7:0] r;
        ahb(0, `USI_ADDR_MODE, 8'h00, r);
        chk("mode reset", mb(3'b111, 1'b0, 2'b00, 1'b0), r);
        ahb(0, `USI_ADDR_SADR, 8'h00, r);
        chk("address reset", 8'h00, r);
        ahb(1, `USI_ADDR_STAT, 8'h18, r);
        ahb(0, `USI_ADDR_STAT, 8'h00, r);
        chk("status outside bus mode", 8'h00, r);
        ahb(1, 8'h14, 8'h5A, r);
        ahb(0, 8'h14, 8'h00, r);
        chk("unmapped", 8'h00, r);
        ahb(1, `USI_ADDR_SADR, 8'hAB, r);
        ahb(0, `USI_ADDR_SADR, 8'h00, r);
        chk("address readback", 8'hAB, r);
    endtask
    // Every mode code with both UART and enable settings
    task automatic t_modes();
        logic [7:0] r, m;
        for (int k = 0; k < 32; k++)
        begin
            m = mb(3'(k >> 2), k[1], 2'b00, k[0]);
            ahb(1, `USI_ADDR_MODE, m, r);
            repeat (3) @(posedge clk_sys);
            chk("spi mode", {7'h00, spi_mode},
                {7'h00, !k[1] && k[0] && (k >> 2) <= 5});
            chk("clock select", {5'h00, spi_clk_sel},
                k[1] ? 8'h07 : 8'(k >> 2));
            ahb(0, `USI_ADDR_MODE, 8'h00, r);
            chk("mode readback", m, r);
        end
    endtask
    task automatic t_enable();
        logic [7:0] r;
        ahb(1, `USI_ADDR_MODE, mb(3'b110, 1'b0, 2'b00, 1'b0), r);
        ahb(1, `USI_ADDR_STAT, 8'h18, r);
        ahb(1, `USI_ADDR_MODE, mb(3'b110, 1'b0, 2'b00, 1'b1), r);
        ahb(0, `USI_ADDR_STAT, 8'h00, r);
        chk("status on enable", 8'h99, r);
        ahb(1, `USI_ADDR_STAT, 8'h00, r);
        ahb(0, `USI_ADDR_STAT, 8'h00, r);
        chk("status cleared", 8'h81, r);
    endtask
    task automatic t_xfer();
        logic [7:0] r;
        mst.start();
        mst.send_byte(8'h54, 0, 0, ack);
        mst.stop();
        chk("foreign address ack", 8'h00, {7'h00, ack});
        mst.start();
        mst.send_byte(8'hAA, 0, 0, ack);
        chk("own address ack", 8'h01, {7'h00, ack});
        ahb(0, `USI_ADDR_STAT, 8'h00, r);
        chk("match flag", 8'h01, {7'h00, r[6]});
        mst.send_byte(8'hC3, 0, 0, ack);
        mst.stop();
        chk("data ack", 8'h01, {7'h00, ack});
        ahb(0, `USI_ADDR_DATA, 8'h00, r);
        chk("received byte", 8'hC3, r);
        ahb(1, `USI_ADDR_DATA, 8'h96, r);
        mst.start();
        mst.send_byte(8'hAB, 0, 0, ack);
        chk("read address ack", 8'h01, {7'h00, ack});
        mst.read_byte(1'b1, r);
        mst.stop();
        chk("sent byte", 8'h96, r);
    endtask
    // Clock glitch against each filter code; last entry has unit off
    task automatic t_debounce();
        logic [7:0] r;
        int deb[6] = '{0, 1, 1, 2, 3, 0};
        int gl[6] = '{1, 1, 3, 3, 3, 0};
        int ex[6] = '{0, 1, 0, 1, 1, 0};
        for (int i = 0; i < 6; i++)
        begin
            ahb(1, `USI_ADDR_MODE, mb(3'b110, 1'b0, 2'(deb[i]), i != 5), r);
            mst.start();
            mst.send_byte(8'hAA, 4, gl[i], ack);
            mst.stop();
            chk("filtered ack", 8'(ex[i]), {7'h00, ack});
        end
    endtask
    initial
    begin
        logic [7:0] r;
        rst = 1'b1;
        clk_en = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        pullup_req = 1'b0;
        err_total = 0;
        check_count = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_enable();
        t_xfer();
        t_debounce();
        pullup_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("pull-up enable", 8'h01, {7'h00, pullup_en});
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        ahb(0, `USI_ADDR_MODE, 8'h00, r);
        chk("mode after reset", 8'hE0, r);
        print_verdict();
    end
endmodule
`default_nettype wire
